// File: logic/tmcc_defines.svh
`ifndef TMCC_DEFINES_SVH
`define TMCC_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TMCC_OFS_CTRL0   8'h00
`define TMCC_OFS_CTRL1   8'h04
`define TMCC_OFS_CTRL2   8'h08
`define TMCC_OFS_PINSEL  8'h0C
`define TMCC_OFS_STAT    8'h10
`define TMCC_OFS_CNT_LO  8'h14
`define TMCC_OFS_CNT_HI  8'h18
`define TMCC_OFS_CMPA_LO 8'h1C
`define TMCC_OFS_CMPA_HI 8'h20
`define TMCC_OFS_PER_LO  8'h24
`define TMCC_OFS_PER_HI  8'h28

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define TMCC_PIN_IN_BIT   0
`define TMCC_PIN_OUT_BIT  1
`define TMCC_PIN_CAPX_BIT 2
`define TMCC_STAT_A_BIT   0
`define TMCC_STAT_P_BIT   1
`define TMCC_RST_BYTE     8'h00
`define TMCC_RST_WORD10   10'h000

// ----------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------
`define TMCC_MODE_CMP    2'h0
`define TMCC_MODE_CAP    2'h1
`define TMCC_MODE_PWM    2'h2
`define TMCC_MODE_TMR    2'h3
`define TMCC_CK_SYS4     3'h0
`define TMCC_CK_SYS      3'h1
`define TMCC_CK_HI16     3'h2
`define TMCC_CK_HI64     3'h3
`define TMCC_CK_SUB0     3'h4
`define TMCC_CK_SUB1     3'h5
`define TMCC_CK_EXTR     3'h6
`define TMCC_CK_EXTF     3'h7
`define TMCC_IO_NONE     2'h0
`define TMCC_IO_LOW      2'h1
`define TMCC_IO_HIGH     2'h2
`define TMCC_IO_TOGGLE   2'h3
`define TMCC_EDGE_RISE   2'h0
`define TMCC_EDGE_FALL   2'h1
`define TMCC_RESP_OKAY   2'h0
`define TMCC_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define TMCC_FULL_SPAN   11'h400
`define TMCC_SYS_DIV_MAX 2'h3
`define TMCC_HI16_MAX    4'hF
`define TMCC_HI64_MAX    6'h3F

`endif

// File: logic/tmcc_pkg.sv
package tmcc_pkg;

  // ----------------------------------------------------------------
  // Timer variants
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TMCC_COMPACT,
    TMCC_STANDARD,
    TMCC_PERIODIC
  } tmcc_variant_e;

  // Single pulse sequencer
  typedef enum logic {
    SP_IDLE,
    SP_RUN
  } tmcc_sp_e;

  // ----------------------------------------------------------------
  // Control register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       pause;
    logic [2:0] counter_clock_select;
    logic       on;
    logic [2:0] compare_p_value;
  } tmcc_ctrl0_s;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] io;
    logic       init_level;
    logic       invert;
    logic       rsv;
    logic       clr_on_a;
  } tmcc_ctrl1_s;

  typedef struct packed {
    logic [4:0] rsv;
    logic       single_pulse;
    logic [1:0] cap_edge;
  } tmcc_ctrl2_s;

endpackage : tmcc_pkg

// File: logic/tmcc_core.sv
`timescale 1ns/100ps
`include "tmcc_defines.svh"

// How it works
// - Free-running up-counter compared against comparators
// - Match raises interrupt, may clear, drive pin
// - Three-bit field picks counter clock source
// - Separate interrupts for comparator A and P
// - External clock pin edge rising or falling
// - Capture edge rising, falling or both
// - External clock pin triggers single pulse
// - Periodic variant captures from clock pin too
// - Compare match drives pin high, low, toggle
// - PWM waveform on the same output pin
// - Pin function bits gate timer pin signals
// - High bytes direct, low bytes via buffer
// - Low-byte comparator write fills buffer only
// - High-byte write also loads buffered low byte
// - High-byte read latches low byte into buffer
// - Low-byte read returns the shared buffer
// - Compact variant: no capture, no single pulse
// - One edge-aligned PWM, period or duty
// - Compact P is three bits on top counter
module tmcc_core #(
  parameter tmcc_pkg::tmcc_variant_e VARIANT = tmcc_pkg::TMCC_PERIODIC
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        HIGH_CLK_TICK,
  input  wire logic        SUB_CLK_TICK,
  input  wire logic        EXT_COUNT_CLOCK_PIN,
  input  wire logic        CAPTURE_INPUT_PIN,
  input  wire logic        INT_ACK_A,
  input  wire logic        INT_ACK_P,
  output logic             TIMER_OUTPUT_PIN,
  output logic             TIMER_OUTPUT_SEL,
  output logic             IRQ_A,
  output logic             IRQ_P,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  localparam logic HAS_CAP = (VARIANT != tmcc_pkg::TMCC_COMPACT);

  tmcc_pkg::tmcc_ctrl0_s ctrl0;
  tmcc_pkg::tmcc_ctrl1_s ctrl1;
  tmcc_pkg::tmcc_ctrl2_s ctrl2;
  tmcc_pkg::tmcc_sp_e    sp_state;
  logic [2:0]  pinsel;
  logic [9:0]  cnt;
  logic [9:0]  cmpa;
  logic [9:0]  per;
  logic [7:0]  byte_buf;
  logic        flag_a;
  logic        flag_p;
  logic        on_q;
  logic        out_lvl;
  logic [1:0]  sys_div;
  logic [5:0]  hi_div;
  logic        ext_q;
  logic        cap_q;
  logic [7:0]  aw_addr;
  logic [7:0]  w_data;
  logic        w_lane0;
  logic        ar_go;
  logic        wr_go;
  logic        wr_en;
  logic        wr_map;
  logic        rd_map;
  logic [7:0]  rd_val;
  logic        ext_in;
  logic        cap_in;
  logic        ext_rise;
  logic        ext_fall;
  logic        cap_ev;
  logic        tick;
  logic        sp_mode;
  logic        sp_trig;
  logic        run;
  logic [10:0] inc;
  logic [10:0] a_tgt;
  logic [10:0] p_tgt;
  logic        match_a;
  logic        match_p;
  logic        on_rise;
  logic        pwm_on;

  // ----------------------------------------------------------------
  // Pin gating and edge detection
  // ----------------------------------------------------------------
  // gate pin inputs
  assign ext_in = EXT_COUNT_CLOCK_PIN & pinsel[`TMCC_PIN_IN_BIT];
  assign cap_in = (VARIANT == tmcc_pkg::TMCC_PERIODIC &&
                   pinsel[`TMCC_PIN_CAPX_BIT]) ? ext_in :
                  (CAPTURE_INPUT_PIN & pinsel[`TMCC_PIN_IN_BIT]);
  assign ext_rise = ext_in & ~ext_q;
  assign ext_fall = ~ext_in & ext_q;

  // Previous pin levels for edge detection
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ext_q <= 1'b0;
      cap_q <= 1'b0;
    end else begin
      ext_q <= ext_in;
      cap_q <= cap_in;
    end
  end

  always_comb begin
    unique case (ctrl2.cap_edge)
      `TMCC_EDGE_RISE: cap_ev = cap_in & ~cap_q;
      `TMCC_EDGE_FALL: cap_ev = ~cap_in & cap_q;
      default:         cap_ev = cap_in ^ cap_q;
    endcase
  end

  // ----------------------------------------------------------------
  // Counter clock selection
  // ----------------------------------------------------------------
  // Prescalers run freely so a source switch needs no resync
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sys_div <= 2'h0;
      hi_div  <= 6'h00;
    end else begin
      sys_div <= sys_div + 2'h1;
      if (HIGH_CLK_TICK) begin
        hi_div <= hi_div + 6'h01;
      end
    end
  end

  always_comb begin
    unique case (ctrl0.counter_clock_select)
      `TMCC_CK_SYS4: tick = (sys_div == `TMCC_SYS_DIV_MAX);
      `TMCC_CK_SYS:  tick = 1'b1;
      `TMCC_CK_HI16: tick = HIGH_CLK_TICK &
                            (hi_div[3:0] == `TMCC_HI16_MAX);
      `TMCC_CK_HI64: tick = HIGH_CLK_TICK & (hi_div == `TMCC_HI64_MAX);
      `TMCC_CK_SUB0: tick = SUB_CLK_TICK;
      `TMCC_CK_SUB1: tick = SUB_CLK_TICK;
      `TMCC_CK_EXTR: tick = ext_rise;
      `TMCC_CK_EXTF: tick = ext_fall;
    endcase
  end

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  // no single pulse in compact
  assign sp_mode = HAS_CAP & ctrl2.single_pulse;
  assign sp_trig = sp_mode & ctrl0.on & ext_rise &
                   (sp_state == tmcc_pkg::SP_IDLE);
  assign run     = ctrl0.on & ~ctrl0.pause &
                   (~sp_mode | (sp_state == tmcc_pkg::SP_RUN));
  assign inc     = {1'b0, cnt} + 11'h001;
  assign on_rise = ctrl0.on & ~on_q;
  // Zero targets stand for a full 1024-count span
  assign a_tgt   = (cmpa == 10'h000) ? `TMCC_FULL_SPAN : {1'b0, cmpa};

  always_comb begin
    if (VARIANT == tmcc_pkg::TMCC_COMPACT) begin
      p_tgt = {1'b0, ctrl0.compare_p_value, 7'h00};
    end else begin
      p_tgt = {1'b0, per};
    end
    if (p_tgt == 11'h000) begin
      p_tgt = `TMCC_FULL_SPAN;
    end
  end

  assign match_a = run & tick & (inc == a_tgt) &
                   (ctrl1.mode != `TMCC_MODE_CAP);
  assign match_p = run & tick & (inc == p_tgt);

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cnt  <= `TMCC_RST_WORD10;
      on_q <= 1'b0;
    end else begin
      on_q <= ctrl0.on;
      if (on_rise || sp_trig) begin
        cnt <= `TMCC_RST_WORD10;
      end else if (run && tick) begin
        if (ctrl1.clr_on_a ? match_a : match_p) begin
          cnt <= `TMCC_RST_WORD10;
        end else begin
          cnt <= inc[9:0];
        end
      end
    end
  end

  // Single pulse runs from trigger to the A match
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sp_state <= tmcc_pkg::SP_IDLE;
    end else if (!sp_mode || !ctrl0.on) begin
      sp_state <= tmcc_pkg::SP_IDLE;
    end else if (sp_trig) begin
      sp_state <= tmcc_pkg::SP_RUN;
    end else if (match_a) begin
      sp_state <= tmcc_pkg::SP_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------
  // edge-aligned duty compare
  assign pwm_on = ctrl1.clr_on_a ? ({1'b0, cnt} < p_tgt) : (cnt < cmpa);

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      out_lvl <= 1'b0;
    end else if (sp_mode) begin
      out_lvl <= (sp_state == tmcc_pkg::SP_RUN) ? ctrl1.init_level :
                 ~ctrl1.init_level;
    end else if (ctrl1.mode == `TMCC_MODE_PWM) begin
      unique case (ctrl1.io)
        `TMCC_IO_NONE: out_lvl <= ~ctrl1.init_level;
        `TMCC_IO_LOW:  out_lvl <= ctrl1.init_level;
        default:       out_lvl <= pwm_on ? ctrl1.init_level :
                                  ~ctrl1.init_level;
      endcase
    end else if (ctrl1.mode == `TMCC_MODE_CMP) begin
      if (on_rise) begin
        out_lvl <= ctrl1.init_level;
      end else if (match_a) begin
        unique case (ctrl1.io)
          `TMCC_IO_NONE:   out_lvl <= out_lvl;
          `TMCC_IO_LOW:    out_lvl <= 1'b0;
          `TMCC_IO_HIGH:   out_lvl <= 1'b1;
          `TMCC_IO_TOGGLE: out_lvl <= ~out_lvl;
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      TIMER_OUTPUT_PIN <= 1'b0;
      TIMER_OUTPUT_SEL <= 1'b0;
    end else begin
      TIMER_OUTPUT_SEL <= pinsel[`TMCC_PIN_OUT_BIT];
      TIMER_OUTPUT_PIN <= pinsel[`TMCC_PIN_OUT_BIT] &
                          (out_lvl ^ ctrl1.invert);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pending flags
  // ----------------------------------------------------------------
  // separate A and P flags
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      flag_a <= 1'b0;
      flag_p <= 1'b0;
    end else begin
      if (match_a || (HAS_CAP && cap_ev && ctrl0.on &&
                      ctrl1.mode == `TMCC_MODE_CAP)) begin
        flag_a <= 1'b1;
      end else if (INT_ACK_A || (wr_en && aw_addr == `TMCC_OFS_STAT &&
                                 w_data[`TMCC_STAT_A_BIT])) begin
        flag_a <= 1'b0;
      end
      if (match_p) begin
        flag_p <= 1'b1;
      end else if (INT_ACK_P || (wr_en && aw_addr == `TMCC_OFS_STAT &&
                                 w_data[`TMCC_STAT_P_BIT])) begin
        flag_p <= 1'b0;
      end
    end
  end

  assign IRQ_A = flag_a;
  assign IRQ_P = flag_p;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign wr_go = ~S_AXI_AWREADY & ~S_AXI_WREADY & ~S_AXI_BVALID;
  assign wr_en = wr_go & w_lane0 & wr_map;
  assign ar_go = S_AXI_ARVALID & S_AXI_ARREADY;

  // Address and data taken in either order, answered after both
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `TMCC_RESP_OKAY;
      aw_addr       <= `TMCC_RST_BYTE;
      w_data        <= `TMCC_RST_BYTE;
      w_lane0       <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        S_AXI_AWREADY <= 1'b0;
        aw_addr       <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        S_AXI_WREADY <= 1'b0;
        w_data       <= S_AXI_WDATA[7:0];
        w_lane0      <= S_AXI_WSTRB[0];
      end
      if (wr_go) begin
        S_AXI_BVALID  <= 1'b1;
        S_AXI_BRESP   <= wr_map ? `TMCC_RESP_OKAY : `TMCC_RESP_SLVERR;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Writable decode; counter bytes are read-only
  always_comb begin
    unique case (aw_addr)
      `TMCC_OFS_CTRL0, `TMCC_OFS_CTRL1, `TMCC_OFS_CTRL2,
      `TMCC_OFS_PINSEL, `TMCC_OFS_STAT, `TMCC_OFS_CMPA_LO,
      `TMCC_OFS_CMPA_HI, `TMCC_OFS_PER_LO,
      `TMCC_OFS_PER_HI: wr_map = 1'b1;
      default:          wr_map = 1'b0;
    endcase
  end

  // Control registers
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctrl0  <= `TMCC_RST_BYTE;
      ctrl1  <= `TMCC_RST_BYTE;
      ctrl2  <= `TMCC_RST_BYTE;
      pinsel <= 3'h0;
    end else if (wr_en) begin
      if (aw_addr == `TMCC_OFS_CTRL0) begin
        ctrl0 <= w_data;
      end
      if (aw_addr == `TMCC_OFS_CTRL1) begin
        ctrl1 <= w_data;
      end
      if (aw_addr == `TMCC_OFS_CTRL2) begin
        ctrl2 <= w_data;
      end
      if (aw_addr == `TMCC_OFS_PINSEL) begin
        pinsel <= w_data[2:0];
      end
    end
  end

  // Comparators; capture yields to a software write
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cmpa <= `TMCC_RST_WORD10;
      per  <= `TMCC_RST_WORD10;
    end else begin
      if (wr_en && aw_addr == `TMCC_OFS_CMPA_HI) begin
        cmpa <= {w_data[1:0], byte_buf};
      end else if (HAS_CAP && cap_ev && ctrl0.on &&
                   ctrl1.mode == `TMCC_MODE_CAP) begin
        cmpa <= cnt;
      end
      if (wr_en && aw_addr == `TMCC_OFS_PER_HI) begin
        per <= {w_data[1:0], byte_buf};
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      byte_buf <= `TMCC_RST_BYTE;
    end else if (wr_en && (aw_addr == `TMCC_OFS_CMPA_LO ||
                           aw_addr == `TMCC_OFS_PER_LO)) begin
      byte_buf <= w_data;
    end else if (ar_go) begin
      unique case (S_AXI_ARADDR)
        `TMCC_OFS_CNT_HI:  byte_buf <= cnt[7:0];
        `TMCC_OFS_CMPA_HI: byte_buf <= cmpa[7:0];
        `TMCC_OFS_PER_HI:  byte_buf <= per[7:0];
        default:           byte_buf <= byte_buf;
      endcase
    end
  end

  // Read data mux
  always_comb begin
    rd_map = 1'b1;
    unique case (S_AXI_ARADDR)
      `TMCC_OFS_CTRL0:   rd_val = ctrl0;
      `TMCC_OFS_CTRL1:   rd_val = ctrl1;
      `TMCC_OFS_CTRL2:   rd_val = ctrl2;
      `TMCC_OFS_PINSEL:  rd_val = {5'h00, pinsel};
      `TMCC_OFS_STAT:    rd_val = {6'h00, flag_p, flag_a};
      `TMCC_OFS_CNT_HI:  rd_val = {6'h00, cnt[9:8]};
      `TMCC_OFS_CMPA_HI: rd_val = {6'h00, cmpa[9:8]};
      `TMCC_OFS_PER_HI:  rd_val = {6'h00, per[9:8]};
      `TMCC_OFS_CNT_LO, `TMCC_OFS_CMPA_LO,
      `TMCC_OFS_PER_LO:  rd_val = byte_buf;
      default: begin
        rd_val = `TMCC_RST_BYTE;
        rd_map = 1'b0;
      end
    endcase
  end

  // One read at a time, answered the cycle after acceptance
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `TMCC_RESP_OKAY;
    end else if (ar_go) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= {24'h00_0000, rd_val};
      S_AXI_RRESP   <= rd_map ? `TMCC_RESP_OKAY : `TMCC_RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule : tmcc_core

// File: verif/tmcc_monitor.sv
`timescale 1ns/100ps
module tmcc_monitor (
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic        INT_ACK_A,
  input wire logic        INT_ACK_P,
  input wire logic        TIMER_OUTPUT_PIN,
  input wire logic        TIMER_OUTPUT_SEL,
  input wire logic        IRQ_A,
  input wire logic        IRQ_P,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  // ------------
  // Register bus
  // ------------
  a_wr_answer:
    assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
      S_AXI_WREADY |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
    else $error("write answer off time");
  a_wr_reopen:
    assert property (S_AXI_BVALID |-> S_AXI_AWREADY && S_AXI_WREADY)
    else $error("write channels closed with response");
  a_b_once:
    assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response repeated");
  a_rd_answer:
    assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
      S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read answer off time");
  a_r_once:
    assert property (S_AXI_RVALID && S_AXI_RREADY |=>
      !S_AXI_RVALID && S_AXI_ARREADY)
    else $error("read response repeated");
  a_rd_upper:
    assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
    else $error("upper read bits set");

  // ------------
  // Pins, flags
  // ------------
  a_pin_gated:
    assert property (!TIMER_OUTPUT_SEL [*3] |-> !TIMER_OUTPUT_PIN)
    else $error("output pin driven while unselected");
  a_a_held:
    assert property ($fell(IRQ_A) |-> $past(INT_ACK_A) ||
      $past(INT_ACK_A, 2) || $rose(S_AXI_BVALID) || $past(S_AXI_BVALID))
    else $error("flag A dropped without clear");
  a_p_apart:
    assert property (INT_ACK_A && !INT_ACK_P && IRQ_P && !S_AXI_BVALID
      |=> IRQ_P)
    else $error("flag P cleared by A acknowledge");
endmodule : tmcc_monitor

bind tmcc_core tmcc_monitor mon (
  .REF_CLK(REF_CLK), .RST(RST), .INT_ACK_A(INT_ACK_A),
  .INT_ACK_P(INT_ACK_P), .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN),
  .TIMER_OUTPUT_SEL(TIMER_OUTPUT_SEL), .IRQ_A(IRQ_A), .IRQ_P(IRQ_P),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY)
);

// File: verif/tmcc_pin_model.sv
`timescale 1ns/100ps
module tmcc_pin_model (
  input  wire logic REF_CLK,
  input  wire logic out_pin,
  output logic      ext_clk,
  output logic      cap_in,
  output int        gap,
  output int        high_len
);
  int   run;
  logic last;

  // Idle low; the count clock stands still between bursts
  initial begin
    ext_clk = 1'b0;
    cap_in  = 1'b0;
  end

  // Last interval between output edges, and last high phase
  always @(posedge REF_CLK) begin
    last <= out_pin;
    run  <= run + 1;
    if (out_pin !== last) begin
      gap <= run;
      run <= 1;
      if (last === 1'b1) high_len <= run;
    end
  end

  // Burst of count pulses, w cycles per phase
  task automatic pulses(input int n, input int w);
    repeat (n) begin
      @(posedge REF_CLK);
      ext_clk <= 1'b1;
      repeat (w) @(posedge REF_CLK);
      ext_clk <= 1'b0;
      repeat (w - 1) @(posedge REF_CLK);
    end
  endtask : pulses

  // New capture pin level
  task automatic cap(input logic v);
    @(posedge REF_CLK);
    cap_in <= v;
  endtask : cap
endmodule : tmcc_pin_model

// File: verif/tb_top.sv
`timescale 1ns/100ps
`include "tmcc_defines.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
  num_errors++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
  end end

module tb_top;
  logic        REF_CLK, RST, HIGH_CLK_TICK, SUB_CLK_TICK, INT_ACK_A;
  logic        EXT_COUNT_CLOCK_PIN, CAPTURE_INPUT_PIN, INT_ACK_P;
  logic        TIMER_OUTPUT_PIN, TIMER_OUTPUT_SEL, IRQ_A, IRQ_P;
  logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
  logic        S_AXI_RVALID, S_AXI_RREADY;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, mbuf;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, q;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
  logic [9:0]  mreg[2];
  logic [9:0]  v;
  int          num_errors, checks, gap, high_len, n, t;
  logic [7:0]  lo_a[2] = '{`TMCC_OFS_CMPA_LO, `TMCC_OFS_PER_LO};
  logic [7:0]  hi_a[2] = '{`TMCC_OFS_CMPA_HI, `TMCC_OFS_PER_HI};
  logic [8:0]  bad[4] = '{{1'b1, `TMCC_OFS_CNT_LO},
    {1'b1, `TMCC_OFS_CNT_HI}, {1'b1, 8'h2C}, {1'b0, 8'h2C}};

  tmcc_core dut (.*);
  tmcc_pin_model pins (
    .REF_CLK  (REF_CLK),
    .out_pin  (TIMER_OUTPUT_PIN),
    .ext_clk  (EXT_COUNT_CLOCK_PIN),
    .cap_in   (CAPTURE_INPUT_PIN),
    .gap      (gap),
    .high_len (high_len)
  );

  // 250 MHz system clock
  initial begin
    REF_CLK = 1'b0;
    forever #2 REF_CLK = ~REF_CLK;
  end

  // ----------
  // Bus tasks
  // ----------
  // One transfer; each valid drops only once taken
  task automatic axi(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge REF_CLK);
    S_AXI_AWADDR  <= a;
    S_AXI_ARADDR  <= a;
    S_AXI_WDATA   <= {24'h000000, d};
    S_AXI_AWVALID <= w;
    S_AXI_WVALID  <= w;
    S_AXI_BREADY  <= w;
    S_AXI_ARVALID <= !w;
    S_AXI_RREADY  <= !w;
    do begin
      @(posedge REF_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!(w ? S_AXI_BVALID : S_AXI_RVALID));
    q = S_AXI_RDATA;
    r = w ? S_AXI_BRESP : S_AXI_RRESP;
    S_AXI_BREADY <= 1'b0;
    S_AXI_RREADY <= 1'b0;
  endtask : axi

  task automatic pwr(input int p, input logic [9:0] d);
    axi(1'b1, lo_a[p], d[7:0]);
    mbuf = d[7:0];
    axi(1'b1, hi_a[p], {6'h00, d[9:8]});
    mreg[p] = {d[9:8], mbuf};
  endtask : pwr

  task automatic prd(input int p);
    axi(1'b0, hi_a[p], 8'h00);
    `CHK("high byte", {6'h00, mreg[p][9:8]}, q[7:0])
    mbuf = mreg[p][7:0];
    axi(1'b0, lo_a[p], 8'h00);
    `CHK("low byte", mbuf, q[7:0])
  endtask : prd

  // Acknowledge pulse on the flag inputs
  task automatic ack(input logic a, input logic p);
    @(posedge REF_CLK);
    INT_ACK_A <= a;
    INT_ACK_P <= p;
    @(posedge REF_CLK);
    INT_ACK_A <= 1'b0;
    INT_ACK_P <= 1'b0;
    repeat (2) @(posedge REF_CLK);
  endtask : ack

  task automatic end_sim;
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  // Hang guard, far beyond the fewer than two thousand cycles needed
  initial begin
    repeat (30000) @(posedge REF_CLK);
    num_errors++;
    end_sim();
  end

  // ----------
  // Scenarios
  // ----------
  initial begin
    void'($urandom(68514));
    RST           = 1'b1;
    HIGH_CLK_TICK = 1'b0;
    SUB_CLK_TICK  = 1'b0;
    INT_ACK_A     = 1'b0;
    INT_ACK_P     = 1'b0;
    S_AXI_AWVALID = 1'b0;
    S_AXI_WVALID  = 1'b0;
    S_AXI_BREADY  = 1'b0;
    S_AXI_ARVALID = 1'b0;
    S_AXI_RREADY  = 1'b0;
    S_AXI_AWADDR  = 8'h00;
    S_AXI_ARADDR  = 8'h00;
    S_AXI_WDATA   = 32'h00000000;
    S_AXI_WSTRB   = 4'hF;
    mreg          = '{10'h000, 10'h000};
    repeat (12) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    `CHK("idle outs", 4'h0, {IRQ_A, IRQ_P, TIMER_OUTPUT_PIN, TIMER_OUTPUT_SEL})
    // Stray low write must not reach the live low byte
    for (int i = 0; i < 6; i++) begin
      v = 10'($urandom);
      axi(1'b1, lo_a[i % 2], v[9:2]);
      prd(i % 2);
      pwr(i % 2, v);
      prd(i % 2);
    end
    foreach (bad[i]) begin
      axi(bad[i][8], bad[i][7:0], 8'h5A);
      `CHK("refused", `TMCC_RESP_SLVERR, r)
    end
    `CHK("refused data", 32'h00000000, q)
    // Timer mode, cleared on P: both flags, then separate clears
    n = 20 + $urandom % 40;
    pwr(1, 10'(n + 30));
    pwr(0, 10'(n));
    axi(1'b1, `TMCC_OFS_CTRL1, 8'hC0);
    axi(1'b1, `TMCC_OFS_CTRL0, 8'h18);
    repeat (n - 4) @(posedge REF_CLK);
    `CHK("A early", 1'b0, IRQ_A)
    repeat (10) @(posedge REF_CLK);
    `CHK("A set", 2'b10, {IRQ_A, IRQ_P})
    repeat (30) @(posedge REF_CLK);
    `CHK("P set", 1'b1, IRQ_P)
    axi(1'b1, `TMCC_OFS_CTRL0, 8'h10);
    ack(1'b1, 1'b0);
    `CHK("ack A", 2'b01, {IRQ_A, IRQ_P})
    axi(1'b1, `TMCC_OFS_STAT, 8'h02);
    `CHK("clear P", 2'b00, {IRQ_A, IRQ_P})
    // Compare output: toggle, low, high; ends high for gating
    t = 16 + $urandom % 32;
    pwr(0, 10'(t));
    axi(1'b1, `TMCC_OFS_PINSEL, 8'h02);
    for (int k = 0; k < 3; k++) begin
      n = (k == 0) ? 3 : k;
      axi(1'b1, `TMCC_OFS_CTRL0, 8'h10);
      axi(1'b1, `TMCC_OFS_CTRL1, {2'h0, 2'(n), 1'(n == 1), 3'h1});
      axi(1'b1, `TMCC_OFS_CTRL0, 8'h18);
      repeat (t / 2) @(posedge REF_CLK);
      `CHK("initial level", 1'(n == 1), TIMER_OUTPUT_PIN)
      repeat (2 * t + 8) @(posedge REF_CLK);
      if (n == 3) `CHK("toggle gap", t, gap)
      else `CHK("match level", 1'(n == 2), TIMER_OUTPUT_PIN)
    end
    axi(1'b1, `TMCC_OFS_PINSEL, 8'h00);
    repeat (4) @(posedge REF_CLK);
    `CHK("gated pin", 2'b00, {TIMER_OUTPUT_PIN, TIMER_OUTPUT_SEL})
    // PWM, active high for the A count, period P
    axi(1'b1, `TMCC_OFS_CTRL0, 8'h10);
    pwr(1, 10'(t + 20));
    axi(1'b1, `TMCC_OFS_PINSEL, 8'h02);
    axi(1'b1, `TMCC_OFS_CTRL1, 8'hA8);
    axi(1'b1, `TMCC_OFS_CTRL0, 8'h18);
    repeat (3 * t + 70) @(posedge REF_CLK);
    `CHK("pwm duty", t, high_len)
    // Pin counting on each edge, then with inputs unselected
    n = 4 + $urandom % 6;
    pwr(0, 10'(n));
    axi(1'b1, `TMCC_OFS_CTRL1, 8'hC1);
    for (int k = 0; k < 3; k++) begin
      axi(1'b1, `TMCC_OFS_PINSEL, {7'h00, 1'(k < 2)});
      axi(1'b1, `TMCC_OFS_CTRL0, {1'b0, 3'((k == 0) ? 6 : 7), 4'h0});
      ack(1'b1, 1'b0);
      axi(1'b1, `TMCC_OFS_CTRL0, {1'b0, 3'((k == 0) ? 6 : 7), 4'h8});
      pins.pulses(n - 1, k + 1);
      repeat (4) @(posedge REF_CLK);
      `CHK("count short", 1'b0, IRQ_A)
      pins.pulses(1, 2);
      repeat (4) @(posedge REF_CLK);
      `CHK("count done", 1'(k < 2), IRQ_A)
    end
    // Capture edges; A matches are masked in capture mode, so only edges set flag A
    pwr(0, 10'h3FF);
    pwr(1, 10'h000);
    axi(1'b1, `TMCC_OFS_CTRL1, 8'h40);
    axi(1'b1, `TMCC_OFS_PINSEL, 8'h01);
    axi(1'b1, `TMCC_OFS_CTRL0, 8'h08);
    for (int e = 0; e < 3; e++) begin
      axi(1'b1, `TMCC_OFS_CTRL2, 8'(e));
      pins.cap(e == 0);
      repeat (4) @(posedge REF_CLK);
      ack(1'b1, 1'b0);
      pins.cap(e != 0);
      repeat (4) @(posedge REF_CLK);
      `CHK("first edge", 1'(e == 2), IRQ_A)
      pins.cap(e == 0);
      repeat (4) @(posedge REF_CLK);
      `CHK("second edge", 1'b1, IRQ_A)
    end
    axi(1'b1, `TMCC_OFS_CTRL2, 8'h00);
    axi(1'b1, `TMCC_OFS_PINSEL, 8'h05);
    ack(1'b1, 1'b0);
    pins.pulses(1, 2);
    repeat (4) @(posedge REF_CLK);
    `CHK("pin capture", 1'b1, IRQ_A)
    end_sim();
  end
endmodule : tb_top
